// ===== flash_prog_consts.vh
// Constants for the flash programming sequencer
// Assumes a single 20 MHz clock and a 32-bit register bus
`ifndef FLASH_PROG_CONSTS_VH
`define FLASH_PROG_CONSTS_VH
// Command codes
`define CMD_WORD_PROG 8'h40
`define CMD_WORD_PROG_ALT 8'h10
`define CMD_BUF_PROG 8'hE8
`define CMD_CONFIRM 8'hD0
`define CMD_FACTORY 8'h80
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_ARRAY 8'hFF
`define CMD_SUSPEND 8'hB0
// Status word bit positions
`define ST_READY 7
`define ST_SEQ_ERR 5
`define ST_PROG_ERR 4
`define ST_SUPPLY_ERR 3
`define ST_LOCK_ERR 1
`define ST_FACT_BUSY 0
// Register byte offsets
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C
`define REG_CTRL 8'h10
`define REG_RDATA 8'h14
// Control register bits
`define CTRL_SUPPLY_OK 0
`define CTRL_FAIL_INJ 1
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// Internal program time per word: 150 ns at the 50 ns clock (count of 2, then the write cycle)
`define PROG_CYCLES 8'h02
// Factory start-up check time, in clocks
`define CHECK_CYCLES 8'h04
`define STATUS_RESET 8'h80
`endif

// ===== flash_array_mem.v
// Flash array storage: one word per entry, program ANDs old with new
// Assumes the caller erases to all ones by array reset only
`default_nettype none
module flash_array_mem #(
  parameter AW = 12,
  parameter DW = 16,
  parameter BLK_W = 10,
  parameter LOCK_BLKS = 4
)(
  input wire aclk,
  input wire aresetn,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data,
  input wire [LOCK_BLKS-1:0] lock_bits,
  input wire [AW-1:0] chk_addr,
  output wire chk_locked
);
  localparam DEPTH = 1 << AW;
  reg [DW-1:0] mem_r [0:DEPTH-1];
  wire [AW-BLK_W-1:0] chk_blk;
  assign chk_blk = chk_addr[AW-1:BLK_W];
  assign chk_locked = lock_bits[chk_blk];
  // Entries reset to erased; programming only clears bits
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_word
      always @(posedge aclk)
      begin
        if (!aresetn)
          mem_r[gi] <= {DW{1'b1}};
        else if (wr_en && wr_addr == gi)
          mem_r[gi] <= mem_r[gi] & wr_data;
      end
    end
  endgenerate
  // Registered read port
  always @(posedge aclk)
  begin
    if (!aresetn)
      rd_data <= {DW{1'b0}};
    else
      rd_data <= mem_r[rd_addr];
  end
endmodule
`default_nettype wire

// ===== flash_program_sequencer.v
// Flash programming sequencer with AXI4-Lite command registers
// Assumes one clock; lock bits arrive as an input level
`default_nettype none
`include "flash_prog_consts.vh"
module flash_program_sequencer #(
  parameter AW = 12,
  parameter BLK_W = 10,
  parameter BUF_WORDS = 512,
  parameter BUF_IW = 9,
  parameter LOCK_BLKS = 4
)(
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [LOCK_BLKS-1:0] block_lock
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_WSETUP = 9'h002;
  localparam [8:0] S_BCOUNT = 9'h004;
  localparam [8:0] S_BFILL = 9'h008;
  localparam [8:0] S_PROG = 9'h010;
  localparam [8:0] S_FSETUP = 9'h020;
  localparam [8:0] S_FCHECK = 9'h040;
  localparam [8:0] S_FFILL = 9'h080;
  localparam [8:0] S_FPROG = 9'h100;
  localparam [AW-1:0] BUF_STEP = BUF_WORDS;
  reg [8:0] state_r;
  reg [7:0] status_word_r;
  reg status_mode_r;
  reg [AW-1:0] addr_r;
  reg [1:0] ctrl_r;
  reg [15:0] wbuf_r [0:BUF_WORDS-1];
  reg [BUF_IW:0] count_r;
  reg [BUF_IW:0] idx_r;
  reg [AW-1:0] start_r;
  reg [AW-1:0] base_r;
  reg [7:0] timer_r;
  reg wmode_r;
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] aw_off_r;
  reg [31:0] w_data_r;
  wire do_write;
  wire [7:0] wr_off;
  wire [31:0] wr_val;
  wire cmd_wr;
  wire data_wr;
  wire [7:0] code;
  wire arr_wen;
  wire [AW-1:0] arr_waddr;
  wire [15:0] arr_wdata;
  wire [15:0] arr_rdata;
  wire chk_locked;
  wire supply_ok;
  wire [AW-1:0] last_addr;
  wire [AW-1:0] blk_mask;
  wire [AW-1:0] buf_off;
  integer k;
  // Write slave: address and data taken in any order, then response
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_off = aw_held_r ? aw_off_r : s_axi_awaddr[7:0];
  assign wr_val = w_held_r ? w_data_r : s_axi_wdata;
  assign do_write = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
    (w_held_r || (s_axi_wvalid && s_axi_wready));
  assign cmd_wr = do_write && wr_off == `REG_CMD;
  assign data_wr = do_write && wr_off == `REG_DATA;
  assign code = wr_val[7:0];
  assign supply_ok = ctrl_r[`CTRL_SUPPLY_OK];
  assign blk_mask = {{(AW-BLK_W){1'b1}}, {BLK_W{1'b0}}};
  assign last_addr = start_r + {{(AW-BUF_IW-1){1'b0}}, count_r} -
    {{(AW-1){1'b0}}, 1'b1};
  // Buffer slot of a later data word, relative to the start address
  assign buf_off = addr_r - start_r;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_off_r <= 8'h00;
      w_data_r <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_off == `REG_CMD || wr_off == `REG_ADDR ||
          wr_off == `REG_DATA || wr_off == `REG_CTRL) ?
          `RESP_OKAY : `RESP_SLVERR;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held_r <= 1'b1;
          aw_off_r <= s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Read slave: data port returns status while status mode holds
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr[7:0])
        `REG_ADDR: s_axi_rdata <= {{(32-AW){1'b0}}, addr_r};
        `REG_STATUS: s_axi_rdata <= {24'h000000, status_word_r};
        `REG_CTRL: s_axi_rdata <= {30'h00000000, ctrl_r};
        `REG_RDATA: s_axi_rdata <= status_mode_r ?
          {24'h000000, status_word_r} : {16'h0000, arr_rdata};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= (s_axi_araddr[7:0] == `REG_CMD ||
            s_axi_araddr[7:0] == `REG_DATA) ? `RESP_OKAY : `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // Address and control registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_r <= {AW{1'b0}};
      ctrl_r <= 2'h1;
    end
    else if (do_write && wr_off == `REG_ADDR && state_r != S_FFILL)
      addr_r <= wr_val[AW-1:0];
    else if (do_write && wr_off == `REG_CTRL)
      ctrl_r <= wr_val[1:0];
  end
  // Array write port: one word per program step
  assign arr_wen = (state_r == S_PROG || state_r == S_FPROG) &&
    timer_r == 8'h00 && !ctrl_r[`CTRL_FAIL_INJ];
  assign arr_waddr = (state_r == S_FPROG) ?
    ((base_r & blk_mask) | ((base_r + {{(AW-BUF_IW-1){1'b0}}, idx_r})
    & ~blk_mask)) :
    (wmode_r ? start_r : start_r + {{(AW-BUF_IW-1){1'b0}}, idx_r});
  assign arr_wdata = wbuf_r[idx_r[BUF_IW-1:0]];
  flash_array_mem #(
    .AW(AW),
    .DW(16),
    .BLK_W(BLK_W),
    .LOCK_BLKS(LOCK_BLKS)
  ) u_array (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(arr_wen),
    .wr_addr(arr_waddr),
    .wr_data(arr_wdata),
    .rd_addr(addr_r),
    .rd_data(arr_rdata),
    .lock_bits(block_lock),
    .chk_addr(addr_r),
    .chk_locked(chk_locked)
  );
  // Write buffer storage, 512 words by default
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (k = 0; k < BUF_WORDS; k = k + 1)
        wbuf_r[k] <= 16'hFFFF;
    end
    else if (data_wr && (state_r == S_WSETUP || state_r == S_BFILL ||
      state_r == S_FFILL))
    begin
      if (state_r == S_WSETUP)
        wbuf_r[0] <= wr_val[15:0];
      else if (state_r == S_BFILL && idx_r == {(BUF_IW+1){1'b0}})
        wbuf_r[0] <= wr_val[15:0];
      else if (state_r == S_BFILL)
        wbuf_r[buf_off[BUF_IW-1:0]] <= wr_val[15:0];
      else
        wbuf_r[idx_r[BUF_IW-1:0]] <= wr_val[15:0];
    end
  end
  // Write state machine
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= S_IDLE;
      status_word_r <= `STATUS_RESET;
      status_mode_r <= 1'b0;
      count_r <= {(BUF_IW+1){1'b0}};
      idx_r <= {(BUF_IW+1){1'b0}};
      start_r <= {AW{1'b0}};
      base_r <= {AW{1'b0}};
      timer_r <= 8'h00;
      wmode_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          if (cmd_wr)
          begin
            status_mode_r <= 1'b1;
            if (code == `CMD_WORD_PROG || code == `CMD_WORD_PROG_ALT)
              state_r <= S_WSETUP;
            else if (code == `CMD_BUF_PROG)
            begin
              status_word_r[`ST_READY] <= 1'b1;
              state_r <= S_BCOUNT;
            end
            else if (code == `CMD_FACTORY)
              state_r <= S_FSETUP;
            else if (code == `CMD_CLEAR_STATUS)
              status_word_r <= `STATUS_RESET;
            else if (code == `CMD_READ_ARRAY)
              status_mode_r <= 1'b0;
          end
        end
        S_WSETUP:
        begin
          if (data_wr)
          begin
            start_r <= addr_r;
            wmode_r <= 1'b1;
            idx_r <= {(BUF_IW+1){1'b0}};
            count_r <= {{BUF_IW{1'b0}}, 1'b1};
            if (chk_locked || !supply_ok)
            begin
              status_word_r[`ST_PROG_ERR] <= 1'b1;
              status_word_r[`ST_LOCK_ERR] <= chk_locked;
              status_word_r[`ST_SUPPLY_ERR] <= !supply_ok;
              state_r <= S_IDLE;
            end
            else
            begin
              status_word_r[`ST_READY] <= 1'b0;
              timer_r <= `PROG_CYCLES;
              state_r <= S_PROG;
            end
          end
        end
        S_BCOUNT:
        begin
          if (data_wr || cmd_wr)
          begin
            count_r <= {1'b0, wr_val[BUF_IW-1:0]} +
              {{BUF_IW{1'b0}}, 1'b1};
            idx_r <= {(BUF_IW+1){1'b0}};
            state_r <= S_BFILL;
          end
        end
        S_BFILL:
        begin
          if (cmd_wr)
          begin
            if (code != `CMD_CONFIRM)
            begin
              status_word_r[`ST_READY] <= 1'b1;
              status_word_r[`ST_SEQ_ERR] <= 1'b1;
              status_word_r[`ST_PROG_ERR] <= 1'b1;
              state_r <= S_IDLE;
            end
            else if ((last_addr & blk_mask) != (start_r & blk_mask))
            begin
              status_word_r[`ST_SEQ_ERR] <= 1'b1;
              status_word_r[`ST_PROG_ERR] <= 1'b1;
              state_r <= S_IDLE;
            end
            else if (!supply_ok || chk_locked)
            begin
              status_word_r[`ST_PROG_ERR] <= 1'b1;
              status_word_r[`ST_SUPPLY_ERR] <= !supply_ok;
              status_word_r[`ST_LOCK_ERR] <= chk_locked;
              state_r <= S_IDLE;
            end
            else
            begin
              wmode_r <= 1'b0;
              idx_r <= {(BUF_IW+1){1'b0}};
              status_word_r[`ST_READY] <= 1'b0;
              timer_r <= `PROG_CYCLES;
              state_r <= S_PROG;
            end
          end
          else if (data_wr)
          begin
            // First data write names the start address
            if (idx_r == {(BUF_IW+1){1'b0}})
              start_r <= addr_r;
            idx_r <= idx_r + {{BUF_IW{1'b0}}, 1'b1};
          end
        end
        S_PROG:
        begin
          if (timer_r != 8'h00)
            timer_r <= timer_r - 8'h01;
          else if (ctrl_r[`CTRL_FAIL_INJ])
          begin
            status_word_r[`ST_READY] <= 1'b1;
            status_word_r[`ST_PROG_ERR] <= 1'b1;
            state_r <= S_IDLE;
          end
          else if (idx_r + {{BUF_IW{1'b0}}, 1'b1} >= count_r)
          begin
            status_word_r[`ST_READY] <= 1'b1;
            state_r <= S_IDLE;
          end
          else
          begin
            idx_r <= idx_r + {{BUF_IW{1'b0}}, 1'b1};
            timer_r <= `PROG_CYCLES;
          end
        end
        S_FSETUP:
        begin
          if (cmd_wr || data_wr)
          begin
            if (cmd_wr && code == `CMD_CONFIRM)
            begin
              base_r <= addr_r;
              status_word_r[`ST_READY] <= 1'b0;
              timer_r <= `CHECK_CYCLES;
              state_r <= S_FCHECK;
            end
            else
            begin
              status_word_r[`ST_SEQ_ERR] <= 1'b1;
              status_word_r[`ST_PROG_ERR] <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_FCHECK:
        begin
          if (timer_r != 8'h00)
            timer_r <= timer_r - 8'h01;
          else if (chk_locked || !supply_ok)
          begin
            status_word_r[`ST_PROG_ERR] <= 1'b1;
            status_word_r[`ST_LOCK_ERR] <= chk_locked;
            status_word_r[`ST_SUPPLY_ERR] <= !supply_ok;
            status_word_r[`ST_READY] <= 1'b1;
            state_r <= S_IDLE;
          end
          else
          begin
            idx_r <= {(BUF_IW+1){1'b0}};
            state_r <= S_FFILL;
          end
        end
        S_FFILL:
        begin
          // Command writes, suspend included, are ignored here
          if (data_wr)
          begin
            if (idx_r == BUF_WORDS - 1)
            begin
              idx_r <= {(BUF_IW+1){1'b0}};
              status_word_r[`ST_FACT_BUSY] <= 1'b1;
              timer_r <= `PROG_CYCLES;
              state_r <= S_FPROG;
            end
            else
              idx_r <= idx_r + {{BUF_IW{1'b0}}, 1'b1};
          end
        end
        S_FPROG:
        begin
          if (timer_r != 8'h00)
            timer_r <= timer_r - 8'h01;
          else if (ctrl_r[`CTRL_FAIL_INJ])
          begin
            status_word_r[`ST_READY] <= 1'b1;
            status_word_r[`ST_PROG_ERR] <= 1'b1;
            status_word_r[`ST_FACT_BUSY] <= 1'b0;
            state_r <= S_IDLE;
          end
          else if (idx_r == BUF_WORDS - 1)
          begin
            idx_r <= {(BUF_IW+1){1'b0}};
            base_r <= (base_r & blk_mask) | ((base_r + BUF_STEP)
              & ~blk_mask);
            status_word_r[`ST_FACT_BUSY] <= 1'b0;
            state_r <= S_FFILL;
          end
          else
          begin
            idx_r <= idx_r + {{BUF_IW{1'b0}}, 1'b1};
            timer_r <= `PROG_CYCLES;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== flash_seq_assertions.sv
// Checker for the sequencer's register bus handshakes
// Assumes it is bound to every sequencer instance in the run
`default_nettype none
module flash_seq_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Response timing and holding on both channels
  wr_resp_due_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_resp_due_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before taken");
  // One transfer at a time per direction; unmapped reads refused; no response during reset
  ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  aw_blocked_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  resp_single_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("extra read response");
  bad_addr_err_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[31:8] == 24'h0 && s_axi_araddr[7:0] > 8'h14
    |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
  reset_quiet_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid)
    else $error("response during reset");
endmodule
bind flash_program_sequencer flash_seq_checker chk_u (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ===== axi_host.sv
// Host model: register bus master issuing flash command cycles
// Assumes the slave answers every request in bounded time
`default_nettype none
module axi_host (
  input wire logic aclk,
  output var logic [31:0] s_axi_awaddr,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0] s_axi_wstrb,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  output var logic [31:0] s_axi_araddr,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  int lag = 0; // Cycles to stall before taking an answer
  // Idle bus at time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // One write, address and data offered together
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready && ++n >= lag) s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // One read, answer taken at the edge where rvalid and rready meet
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready && ++n >= lag) s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Testbench for the flash programming sequencer
// Assumes the host model and the bound checker are compiled with it
`default_nettype none
`include "flash_prog_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {logic [31:0] e; logic [31:0] m; logic [1:0] r;} note_t;
  localparam logic [31:0] CMD = {24'h0, `REG_CMD}, ADR = {24'h0, `REG_ADDR};
  localparam logic [31:0] DAT = {24'h0, `REG_DATA}, ST = {24'h0, `REG_STATUS};
  localparam logic [31:0] CTL = {24'h0, `REG_CTRL}, RD = {24'h0, `REG_RDATA};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] block_lock = 4'h0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'hDF8B;
  note_t notes[$];
  note_t nt;
  logic [15:0] mem [0:31]; // Expected array words, low addresses only
  flash_program_sequencer dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .block_lock);
  axi_host host_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  // Clock, 50 ns period
  always #25 aclk = ~aclk;
  task automatic give_verdict;
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic expect_rd(input logic [31:0] a, e, m, input logic [1:0] r);
    notes.push_back('{e, m, r});
    host_u.rd(a, rd);
  endtask
  task automatic wr(input logic [31:0] a, dv);
    host_u.wr(a, dv, rs);
    check("bresp", {30'h0, `RESP_OKAY}, {30'h0, rs});
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do
    begin
      expect_rd(RD, 32'h0, 32'h0, `RESP_OKAY);
      k++;
    end
    while (rd[b] !== v && k < 3000);
    check("poll", {31'h0, v}, {31'h0, rd[b]});
  endtask
  // Random word at address a; the model keeps only cleared bits
  task automatic put(input logic [31:0] a, input bit upd);
    d = $random(seed);
    wr(ADR, a);
    wr(DAT, {16'h0, d[15:0]});
    if (upd) mem[a] = mem[a] & d[15:0];
  endtask
  task automatic bufprog(input int a0, n, input logic [7:0] c, input bit u);
    wr(CMD, `CMD_BUF_PROG);
    expect_rd(ST, 32'h80, 32'h80, `RESP_OKAY);
    wr(DAT, n - 1);
    for (int i = 0; i < n; i++) put(a0 + i, u);
    wr(CMD, c);
    poll(7, 1'b1);
  endtask
  // Watchdog well beyond the expected run length
  initial
  begin
    #2_000_000;
    check("watchdog", 32'h0, 32'h1);
    give_verdict();
  end
  // Every read answer is matched against the oldest note
  always @(posedge aclk)
    if (aresetn && s_axi_rvalid && s_axi_rready)
    begin
      nt = notes.pop_front();
      check("rresp", {30'h0, nt.r}, {30'h0, s_axi_rresp});
      if (nt.m != 0) check("rdata", nt.e & nt.m, s_axi_rdata & nt.m);
    end
  // Main sequence
  initial
  begin
    for (int i = 0; i < 32; i++) mem[i] = 16'hFFFF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    expect_rd(ST, 32'h80, 32'hFF, `RESP_OKAY);
    expect_rd(CTL, 32'h1, 32'h3, `RESP_OKAY);
    expect_rd(32'h40, 32'h0, 32'h0, `RESP_SLVERR);
    host_u.wr(32'h44, 32'h0, rs);
    check("bresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
    for (int i = 0; i < 2; i++)
    begin
      wr(CMD, i ? `CMD_WORD_PROG_ALT : `CMD_WORD_PROG);
      put(5, 1);
      poll(7, 1'b1);
      expect_rd(RD, 32'h80, 32'hFF, `RESP_OKAY);
      wr(CMD, `CMD_READ_ARRAY);
      expect_rd(RD, {16'h0, mem[5]}, 32'hFFFF, `RESP_OKAY);
    end
    host_u.lag = 2;
    block_lock <= 4'h2;
    wr(CMD, `CMD_WORD_PROG);
    put(1027, 0);
    poll(7, 1'b1);
    expect_rd(ST, 32'h92, 32'hFF, `RESP_OKAY);
    wr(CMD, `CMD_CLEAR_STATUS);
    host_u.lag = 0;
    block_lock <= 4'h0;
    wr(CTL, 32'h0);
    wr(CMD, `CMD_WORD_PROG);
    put(6, 0);
    poll(7, 1'b1);
    expect_rd(ST, 32'h88, 32'h88, `RESP_OKAY);
    wr(CMD, `CMD_CLEAR_STATUS);
    bufprog(8, 1, `CMD_CONFIRM, 0);
    expect_rd(ST, 32'h18, 32'h18, `RESP_OKAY);
    wr(CMD, `CMD_CLEAR_STATUS);
    wr(CTL, 32'h1);
    bufprog(16, 4, `CMD_CONFIRM, 1);
    wr(CMD, `CMD_READ_ARRAY);
    for (int i = 16; i < 20; i++)
    begin
      wr(ADR, i);
      expect_rd(RD, {16'h0, mem[i]}, 32'hFFFF, `RESP_OKAY);
    end
    bufprog(32, 1, `CMD_WORD_PROG, 0);
    expect_rd(ST, 32'hB0, 32'hFF, `RESP_OKAY);
    wr(CMD, `CMD_CLEAR_STATUS);
    bufprog(1022, 4, `CMD_CONFIRM, 0);
    expect_rd(ST, 32'h30, 32'h30, `RESP_OKAY);
    wr(CMD, `CMD_CLEAR_STATUS);
    wr(CTL, 32'h3);
    bufprog(40, 2, `CMD_CONFIRM, 0);
    expect_rd(ST, 32'h90, 32'h90, `RESP_OKAY);
    wr(CMD, `CMD_CLEAR_STATUS);
    wr(CTL, 32'h1);
    block_lock <= 4'h8;
    wr(ADR, 32'hC00);
    wr(CMD, `CMD_FACTORY);
    wr(CMD, `CMD_CONFIRM);
    poll(7, 1'b1);
    expect_rd(ST, 32'h92, 32'h9A, `RESP_OKAY);
    wr(CMD, `CMD_CLEAR_STATUS);
    block_lock <= 4'h0;
    wr(ADR, 32'h800);
    wr(CMD, `CMD_FACTORY);
    wr(CMD, `CMD_CONFIRM);
    expect_rd(RD, 32'h0, 32'h80, `RESP_OKAY);
    repeat (`CHECK_CYCLES) @(posedge aclk);
    for (int i = 0; i < 512; i++)
    begin
      d = $random(seed);
      wr(DAT, i < 500 ? {16'h0, d[15:0]} : 32'hFFFF);
    end
    wr(CMD, `CMD_SUSPEND);
    expect_rd(RD, 32'h1, 32'h85, `RESP_OKAY);
    poll(0, 1'b0);
    expect_rd(RD, 32'h0, 32'h80, `RESP_OKAY);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    expect_rd(ST, 32'h80, 32'hFF, `RESP_OKAY);
    give_verdict();
  end
endmodule
`default_nettype wire
